// ### design/pmcr_defs.svh
// offsets, field codes, reset values and limits of the modem control bank
// assumes it is included by bare name from the package and the bank module
`ifndef PMCR_DEFS_SVH
`define PMCR_DEFS_SVH

// bank size and control byte offsets
`define PMCR_NUM_REGS 8'd38
`define PMCR_IDX_W 6
`define PMCR_OFS_CLK_LO 8'd0
`define PMCR_OFS_CLK_MID 8'd1
`define PMCR_OFS_CLK_HI 8'd2
`define PMCR_OFS_SYM_EXP 8'd3
`define PMCR_OFS_TX_MOD 8'd4
`define PMCR_OFS_TX_SRC 8'd5
`define PMCR_OFS_GAIN_LO 8'd6
`define PMCR_OFS_GAIN_HI 8'd7
`define PMCR_OFS_TXF_B0 8'd8
`define PMCR_OFS_TXF_B3 8'd11
`define PMCR_OFS_TX_CODING 8'd12
`define PMCR_OFS_IBR_B0 8'd13
`define PMCR_OFS_IBR_B3 8'd16
`define PMCR_OFS_EXT_GAIN_LO 8'd17
`define PMCR_OFS_EXT_GAIN_HI 8'd18
`define PMCR_OFS_EXT_CTRL 8'd19
`define PMCR_OFS_SCAN 8'd24
`define PMCR_OFS_RSR_B0 8'd25
`define PMCR_OFS_RSR_B3 8'd28
`define PMCR_OFS_RXF_B0 8'd29
`define PMCR_OFS_RXF_B3 8'd32
`define PMCR_OFS_RX_MOD 8'd33
`define PMCR_OFS_AGC 8'd34
`define PMCR_OFS_RX_INPUT 8'd35
`define PMCR_OFS_RX_DECODING 8'd37

// reset value of every control byte
`define PMCR_RESET_BYTE 8'h00

// field codes and limits
`define PMCR_CLK_WORD_MAX 20'h66666
`define PMCR_SYM_EXP_MIN 4'h1
`define PMCR_FEC_CODE_MIN 4'h1
`define PMCR_FEC_CODE_MAX 4'h5
`define PMCR_MOD_CODE_MAX 6'h02
`define PMCR_SRC_PRBS 4'h3
`define PMCR_SRC_CARRIER 4'h5
`define PMCR_AGC_EXP_MAX 5'h0e
`define PMCR_AGC_MAX_GAIN 9'h100
`define PMCR_IN_COMPLEX 3'h1
`define PMCR_IN_LOOPBACK 3'h7

`endif

// ### design/pmcr_pkg.sv
// types shared by the modem control bank
// assumes the defs header is on the include path
package pmcr_pkg;
`include "pmcr_defs.svh"

   // all flip-flops of the bank
   typedef struct packed {
      logic wr_s1;
      logic wr_s2;
      logic wr_s3;
      logic [7:0] addr_s1;
      logic [7:0] addr_s2;
      logic [7:0] data_s1;
      logic [7:0] data_s2;
      logic [37:0][7:0] ctl;
      logic [19:0] clk_word;
      logic [15:0] gain;
      logic [31:0] tx_freq;
      logic [31:0] in_bit_rate;
      logic [11:0] ext_gain;
      logic [31:0] rx_sym_rate;
      logic [31:0] rx_freq;
      logic [3:0] sym_exp;
      logic [4:0] agc_exp;
      logic [8:0] agc_max_gain;
      logic tx_src_valid;
      logic tx_mod_valid;
      logic tx_fec_valid;
      logic rx_mod_valid;
      logic rx_fec_valid;
      logic rx_in_valid;
   } pmcr_state_type;
endpackage

// ### design/pmcr_bank.sv
// write-only control byte bank of the psk modem, with field decode
// assumes an asynchronous microcontroller bus: address and data held
// steady while the write strobe is high, strobe high for >= 3 clocks
//
// Notes on behaviour
// - eight-bit bytes written over address/data bus
// - low nibble of byte 5 picks source
// - byte 12 bits 4:1 code, bit 6 bypass
// - byte 12 bit 5 enables differential encoding
// - byte 12 bit 7 bypasses scrambler
// - byte 12 bit 0 bypasses hdlc framing
// - twenty-bit clock word, capped at 120 MHz
// - byte 2 bit 7 picks external reference
// - symbol rate exponent one to fifteen
// - byte 4 bits 5:0 pick tx modulation
// - byte 4 bit 6 inverts tx q
// - byte 4 bit 7 bypasses shaping filters
// - sixteen-bit gain, bytes 6 and 7
// - tx centre frequency, bytes 8 to 11
// - rx symbol rate, bytes 25 to 28
// - rx centre frequency, bytes 29 to 32
// - byte 33 rx modulation and q invert
// - byte 24 sets scan step count
// - agc response exponent zero to fourteen
// - agc source select, internal-loop gain capped 256
// - byte 35 bits 2:0 pick rx input
// - byte 37 decoder code and differential
`timescale 1ns/1ps
`include "pmcr_defs.svh"

module pmcr_bank
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic UC_WR,
   input wire logic [7:0] UC_ADDR,
   input wire logic [7:0] UC_DATA,
   output logic [19:0] TX_CLOCK_WORD,
   output logic TX_REF_EXTERNAL,
   output logic [3:0] TX_SYM_EXP,
   output logic [5:0] TX_MOD_TYPE,
   output logic TX_MOD_VALID,
   output logic TX_Q_INVERT,
   output logic TX_FILTER_BYPASS,
   output logic [3:0] TX_SOURCE,
   output logic TX_SOURCE_VALID,
   output logic [15:0] TX_GAIN,
   output logic [31:0] TX_CENTER_FREQ,
   output logic [3:0] TX_FEC_CODE,
   output logic TX_FEC_VALID,
   output logic TX_FEC_BYPASS,
   output logic TX_DIFF_ENCODE,
   output logic TX_SCRAMBLE_BYPASS,
   output logic TX_HDLC_BYPASS,
   output logic [31:0] TX_INPUT_BIT_RATE,
   output logic [11:0] TX_EXT_GAIN,
   output logic TRANSMIT_ENABLE_OUT,
   output logic RECEIVE_NOT_TRANSMIT_OUT,
   output logic [7:0] RX_SCAN_STEPS,
   output logic [31:0] RX_SYMBOL_RATE,
   output logic [31:0] RX_CENTER_FREQ,
   output logic [5:0] RX_MOD_TYPE,
   output logic RX_MOD_VALID,
   output logic RX_Q_INVERT,
   output logic RX_HIGH_SNR,
   output logic [4:0] RX_AGC_EXP,
   output logic RX_AGC_EXTERNAL,
   output logic [8:0] RX_AGC_MAX_GAIN,
   output logic [2:0] RX_INPUT_SEL,
   output logic RX_INPUT_VALID,
   output logic [3:0] RX_FEC_CODE,
   output logic RX_FEC_VALID,
   output logic RX_DIFF_DECODE
);
   import pmcr_pkg::*;

   pmcr_state_type st_reg;
   pmcr_state_type st_next;
   logic wr_evt;
   logic [`PMCR_IDX_W-1:0] evt_idx;
   logic [7:0] b12;
   logic [7:0] b4;

   // convolutional code 0001..0101 is a usable rate
   function automatic logic fec_ok(input logic [3:0] code);
      fec_ok = (code >= `PMCR_FEC_CODE_MIN) && (code <= `PMCR_FEC_CODE_MAX);
   endfunction

   // modulation 0..2 is bpsk, qpsk or oqpsk
   function automatic logic mod_ok(input logic [5:0] code);
      mod_ok = (code <= `PMCR_MOD_CODE_MAX);
   endfunction

   // rising edge of the synchronised strobe; address and data are settled
   assign wr_evt = st_reg.wr_s2 & ~st_reg.wr_s3;
   assign evt_idx = st_reg.addr_s2[`PMCR_IDX_W-1:0];
   assign b12 = st_reg.ctl[`PMCR_OFS_TX_CODING];
   assign b4 = st_reg.ctl[`PMCR_OFS_TX_MOD];

   // next-state logic: synchronise, store the byte, commit words, decode
   always_comb
   begin
      st_next = st_reg;
      // pins pass two stages; the third only delays for the edge
      st_next.wr_s1 = UC_WR;
      st_next.wr_s2 = st_reg.wr_s1;
      st_next.wr_s3 = st_reg.wr_s2;
      st_next.addr_s1 = UC_ADDR;
      st_next.addr_s2 = st_reg.addr_s1;
      st_next.data_s1 = UC_DATA;
      st_next.data_s2 = st_reg.data_s1;
      if (wr_evt && (st_reg.addr_s2 < `PMCR_NUM_REGS))
      begin
         st_next.ctl[evt_idx] = st_reg.data_s2;
      end
      // whole-word commit on top byte, low bytes written first
      if (wr_evt)
      begin
         case (st_reg.addr_s2)
            // clock word capped at 120 MHz
            `PMCR_OFS_CLK_HI:
            begin
               st_next.clk_word = {st_reg.data_s2[3:0],
                                   st_reg.ctl[`PMCR_OFS_CLK_MID],
                                   st_reg.ctl[`PMCR_OFS_CLK_LO]};
               if (st_next.clk_word > `PMCR_CLK_WORD_MAX)
               begin
                  st_next.clk_word = `PMCR_CLK_WORD_MAX;
               end
            end
            `PMCR_OFS_GAIN_HI:
            begin
               st_next.gain = {st_reg.data_s2, st_reg.ctl[`PMCR_OFS_GAIN_LO]};
            end
            `PMCR_OFS_TXF_B3:
            begin
               st_next.tx_freq = {st_reg.data_s2,
                                  st_reg.ctl[`PMCR_OFS_TXF_B0 + 8'd2],
                                  st_reg.ctl[`PMCR_OFS_TXF_B0 + 8'd1],
                                  st_reg.ctl[`PMCR_OFS_TXF_B0]};
            end
            `PMCR_OFS_IBR_B3:
            begin
               st_next.in_bit_rate = {st_reg.data_s2,
                                      st_reg.ctl[`PMCR_OFS_IBR_B0 + 8'd2],
                                      st_reg.ctl[`PMCR_OFS_IBR_B0 + 8'd1],
                                      st_reg.ctl[`PMCR_OFS_IBR_B0]};
            end
            `PMCR_OFS_EXT_GAIN_HI:
            begin
               st_next.ext_gain = {st_reg.data_s2[3:0],
                                   st_reg.ctl[`PMCR_OFS_EXT_GAIN_LO]};
            end
            `PMCR_OFS_RSR_B3:
            begin
               st_next.rx_sym_rate = {st_reg.data_s2,
                                      st_reg.ctl[`PMCR_OFS_RSR_B0 + 8'd2],
                                      st_reg.ctl[`PMCR_OFS_RSR_B0 + 8'd1],
                                      st_reg.ctl[`PMCR_OFS_RSR_B0]};
            end
            `PMCR_OFS_RXF_B3:
            begin
               st_next.rx_freq = {st_reg.data_s2,
                                  st_reg.ctl[`PMCR_OFS_RXF_B0 + 8'd2],
                                  st_reg.ctl[`PMCR_OFS_RXF_B0 + 8'd1],
                                  st_reg.ctl[`PMCR_OFS_RXF_B0]};
            end
            default:
            begin
               st_next.gain = st_reg.gain;
            end
         endcase
      end
      // exponent zero is out of range, treated as one
      st_next.sym_exp = st_next.ctl[`PMCR_OFS_SYM_EXP][3:0];
      if (st_next.sym_exp < `PMCR_SYM_EXP_MIN)
      begin
         st_next.sym_exp = `PMCR_SYM_EXP_MIN;
      end
      st_next.agc_exp = st_next.ctl[`PMCR_OFS_AGC][4:0];
      if (st_next.agc_exp > `PMCR_AGC_EXP_MAX)
      begin
         st_next.agc_exp = `PMCR_AGC_EXP_MAX;
      end
      // gain cap applies to the internal loop only
      st_next.agc_max_gain = st_next.ctl[`PMCR_OFS_AGC][7] ? 9'h000 : `PMCR_AGC_MAX_GAIN;
      // source codes 0..3 and 5 are usable
      st_next.tx_src_valid = (st_next.ctl[`PMCR_OFS_TX_SRC][3:0] <= `PMCR_SRC_PRBS) ||
                             (st_next.ctl[`PMCR_OFS_TX_SRC][3:0] == `PMCR_SRC_CARRIER);
      st_next.tx_mod_valid = mod_ok(st_next.ctl[`PMCR_OFS_TX_MOD][5:0]);
      st_next.tx_fec_valid = fec_ok(st_next.ctl[`PMCR_OFS_TX_CODING][4:1]);
      st_next.rx_mod_valid = mod_ok(st_next.ctl[`PMCR_OFS_RX_MOD][5:0]);
      st_next.rx_fec_valid = fec_ok(st_next.ctl[`PMCR_OFS_RX_DECODING][4:1]);
      st_next.rx_in_valid = (st_next.ctl[`PMCR_OFS_RX_INPUT][2:0] <= `PMCR_IN_COMPLEX) ||
                            (st_next.ctl[`PMCR_OFS_RX_INPUT][2:0] == `PMCR_IN_LOOPBACK);
   end

   // single state register; reset gives zero bytes and zero words
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         st_reg <= '0;
         st_reg.sym_exp <= `PMCR_SYM_EXP_MIN;
         st_reg.agc_max_gain <= `PMCR_AGC_MAX_GAIN;
         st_reg.tx_src_valid <= 1'b1;
         st_reg.tx_mod_valid <= 1'b1;
         st_reg.rx_mod_valid <= 1'b1;
         st_reg.rx_in_valid <= 1'b1;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // transmit side outputs, all straight from state flops
   assign TX_CLOCK_WORD = st_reg.clk_word;
   assign TX_REF_EXTERNAL = st_reg.ctl[`PMCR_OFS_CLK_HI][7];
   assign TX_SYM_EXP = st_reg.sym_exp;
   assign TX_MOD_TYPE = b4[5:0];
   assign TX_MOD_VALID = st_reg.tx_mod_valid;
   assign TX_Q_INVERT = b4[6];
   assign TX_FILTER_BYPASS = b4[7];
   assign TX_SOURCE = st_reg.ctl[`PMCR_OFS_TX_SRC][3:0];
   assign TX_SOURCE_VALID = st_reg.tx_src_valid;
   assign TX_GAIN = st_reg.gain;
   assign TX_CENTER_FREQ = st_reg.tx_freq;
   assign TX_FEC_CODE = b12[4:1];
   assign TX_FEC_VALID = st_reg.tx_fec_valid;
   assign TX_FEC_BYPASS = b12[6];
   assign TX_DIFF_ENCODE = b12[5];
   // scrambler bypass, scrambler sits ahead of the encoder
   assign TX_SCRAMBLE_BYPASS = b12[7];
   assign TX_HDLC_BYPASS = b12[0];
   assign TX_INPUT_BIT_RATE = st_reg.in_bit_rate;
   assign TX_EXT_GAIN = st_reg.ext_gain;
   assign TRANSMIT_ENABLE_OUT = st_reg.ctl[`PMCR_OFS_EXT_CTRL][0];
   assign RECEIVE_NOT_TRANSMIT_OUT = st_reg.ctl[`PMCR_OFS_EXT_CTRL][1];

   // receive side outputs
   // scan step count, step spacing is the demodulator's
   assign RX_SCAN_STEPS = st_reg.ctl[`PMCR_OFS_SCAN];
   assign RX_SYMBOL_RATE = st_reg.rx_sym_rate;
   assign RX_CENTER_FREQ = st_reg.rx_freq;
   assign RX_MOD_TYPE = st_reg.ctl[`PMCR_OFS_RX_MOD][5:0];
   assign RX_MOD_VALID = st_reg.rx_mod_valid;
   assign RX_Q_INVERT = st_reg.ctl[`PMCR_OFS_RX_MOD][6];
   assign RX_HIGH_SNR = st_reg.ctl[`PMCR_OFS_RX_MOD][7];
   assign RX_AGC_EXP = st_reg.agc_exp;
   assign RX_AGC_EXTERNAL = st_reg.ctl[`PMCR_OFS_AGC][7];
   assign RX_AGC_MAX_GAIN = st_reg.agc_max_gain;
   assign RX_INPUT_SEL = st_reg.ctl[`PMCR_OFS_RX_INPUT][2:0];
   assign RX_INPUT_VALID = st_reg.rx_in_valid;
   assign RX_FEC_CODE = st_reg.ctl[`PMCR_OFS_RX_DECODING][4:1];
   assign RX_FEC_VALID = st_reg.rx_fec_valid;
   assign RX_DIFF_DECODE = st_reg.ctl[`PMCR_OFS_RX_DECODING][5];

   // checks on the bank, all in the CLK domain
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);

   // a settled write strobe edge at one offset
   sequence s_wr_at(logic [7:0] a);
      wr_evt && (st_reg.addr_s2 == a);
   endsequence

   // pin strobe rising, then two quiet synchroniser stages
   sequence s_pin_rise;
      !UC_WR ##1 UC_WR [*3];
   endsequence

   // strobe seen two clocks after the pin
   chk_strobe_sync: assert property (s_pin_rise |-> wr_evt)
      else $error("write strobe not seen after sync");

   // written byte lands one clock after the edge
   chk_byte_store: assert property ((wr_evt && st_reg.addr_s2 < `PMCR_NUM_REGS)
      |=> st_reg.ctl[$past(evt_idx)] == $past(st_reg.data_s2))
      else $error("control byte not stored");

   // low clock bytes alone leave the word alone
   chk_clk_coherent: assert property ((s_wr_at(`PMCR_OFS_CLK_LO) or
      s_wr_at(`PMCR_OFS_CLK_MID)) |=> $stable(TX_CLOCK_WORD))
      else $error("clock word moved on a low byte");

   // word never above the 120 MHz code
   chk_clk_limit: assert property (TX_CLOCK_WORD <= `PMCR_CLK_WORD_MAX)
      else $error("clock word above limit");

   // top byte commits all four bytes in order
   chk_txf_commit: assert property (s_wr_at(`PMCR_OFS_TXF_B3) |=>
      TX_CENTER_FREQ == {$past(st_reg.data_s2), st_reg.ctl[10],
      st_reg.ctl[9], st_reg.ctl[8]})
      else $error("tx frequency word wrong");

   // rx frequency holds for two clocks after its low byte is written
   chk_rxf_hold: assert property (s_wr_at(`PMCR_OFS_RXF_B0) |=>
      $stable(RX_CENTER_FREQ) [*2])
      else $error("rx frequency moved early");

   // exponent stays in one to fifteen
   chk_sym_exp: assert property (TX_SYM_EXP >= `PMCR_SYM_EXP_MIN)
      else $error("symbol exponent zero");

   chk_agc_range: assert property (RX_AGC_EXP <= `PMCR_AGC_EXP_MAX)
      else $error("agc exponent above fourteen");

   // gain cap only on the internal loop
   chk_agc_cap: assert property (RX_AGC_EXTERNAL ||
      RX_AGC_MAX_GAIN == `PMCR_AGC_MAX_GAIN)
      else $error("internal agc cap wrong");

   chk_fec_valid: assert property (TX_FEC_VALID ==
      (TX_FEC_CODE >= 4'h1 && TX_FEC_CODE <= 4'h5))
      else $error("encoder code validity wrong");

   // a write to the source byte shows next clock
   chk_src_write: assert property (s_wr_at(`PMCR_OFS_TX_SRC) |=>
      TX_SOURCE == $past(st_reg.data_s2[3:0]))
      else $error("source select not applied");

   chk_src_valid: assert property (TX_SOURCE_VALID ==
      (TX_SOURCE <= `PMCR_SRC_PRBS || TX_SOURCE == `PMCR_SRC_CARRIER))
      else $error("source validity wrong");

   chk_mod_valid: assert property (TX_MOD_VALID ==
      (TX_MOD_TYPE <= `PMCR_MOD_CODE_MAX))
      else $error("tx modulation validity wrong");

   // top gain byte commits both bytes
   chk_gain_commit: assert property (s_wr_at(`PMCR_OFS_GAIN_HI) |=>
      TX_GAIN == {$past(st_reg.data_s2), st_reg.ctl[`PMCR_OFS_GAIN_LO]})
      else $error("gain word wrong");

   // low gain byte alone leaves the word alone
   chk_gain_hold: assert property (s_wr_at(`PMCR_OFS_GAIN_LO) |=>
      $stable(TX_GAIN))
      else $error("gain moved on the low byte");

   // top byte commits the rx symbol rate
   chk_rsr_commit: assert property (s_wr_at(`PMCR_OFS_RSR_B3) |=>
      RX_SYMBOL_RATE == {$past(st_reg.data_s2), st_reg.ctl[27],
      st_reg.ctl[26], st_reg.ctl[25]})
      else $error("rx symbol rate word wrong");

   chk_in_valid: assert property (RX_INPUT_VALID ==
      (RX_INPUT_SEL <= `PMCR_IN_COMPLEX || RX_INPUT_SEL == `PMCR_IN_LOOPBACK))
      else $error("rx input validity wrong");

   chk_dec_valid: assert property (RX_FEC_VALID ==
      (RX_FEC_CODE >= `PMCR_FEC_CODE_MIN && RX_FEC_CODE <= `PMCR_FEC_CODE_MAX))
      else $error("decoder code validity wrong");

endmodule

// ### dv/pmcr_uc_model.sv
// microcontroller write-side model for the modem control bank
// assumes the bank samples its strobe on the rising edge of clk
`timescale 1ns/1ps

module pmcr_uc_model
(
   input wire logic clk,
   output logic uc_wr,
   output logic [7:0] uc_addr,
   output logic [7:0] uc_data
);
   // idle bus, strobe low from time zero
   initial
   begin
      uc_wr = 1'b0;
      uc_addr = 8'hff;
      uc_data = 8'hff;
   end

   // whole byte per strobe
   // lines set a clock before the strobe, which stays high 3 clocks
   task automatic write_byte(input logic [7:0] addr, input logic [7:0] data);
      @(posedge clk) #1;
      uc_addr = addr;
      uc_data = data;
      @(posedge clk) #1;
      uc_wr = 1'b1;
      repeat (3) @(posedge clk);
      #1 uc_wr = 1'b0;
      repeat (2) @(posedge clk);
      // released lines show the inverse so a stale capture shows up
      #1 uc_addr = ~addr;
      uc_data = ~data;
      @(posedge clk) #1;
   endtask
endmodule

// ### dv/psk_modem_control_registers_test.sv
// self-checking bench for the modem control bank
// assumes the defs header on the include path and the uc model beside it
`timescale 1ns/1ps
`include "pmcr_defs.svh"

module psk_modem_control_registers_test;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic uc_wr;
   logic [7:0] uc_addr, uc_data;
   logic [19:0] tx_clock_word;
   logic [31:0] tx_center_freq, tx_input_bit_rate, rx_symbol_rate, rx_center_freq;
   logic [15:0] tx_gain;
   logic [11:0] tx_ext_gain;
   logic [8:0] rx_agc_max_gain;
   logic [7:0] rx_scan_steps;
   logic [5:0] tx_mod_type, rx_mod_type;
   logic [4:0] rx_agc_exp;
   logic [3:0] tx_sym_exp, tx_source, tx_fec_code, rx_fec_code;
   logic [2:0] rx_input_sel;
   logic tx_ref_external, tx_mod_valid, tx_q_invert, tx_filter_bypass, tx_source_valid;
   logic tx_fec_valid, tx_fec_bypass, tx_diff_encode, tx_scramble_bypass, tx_hdlc_bypass;
   logic transmit_enable_out, receive_not_transmit_out, rx_mod_valid, rx_q_invert;
   logic rx_high_snr, rx_agc_external, rx_input_valid, rx_fec_valid, rx_diff_decode;
   int n_fail = 0;
   int samples_checked = 0;

   // 50 MHz clock
   always #10 clk = ~clk;

   pmcr_uc_model u_uc (.clk(clk), .uc_wr(uc_wr), .uc_addr(uc_addr), .uc_data(uc_data));

   pmcr_bank u_dut (.CLK(clk), .RST(rst), .UC_WR(uc_wr), .UC_ADDR(uc_addr),
      .UC_DATA(uc_data), .TX_CLOCK_WORD(tx_clock_word), .TX_REF_EXTERNAL(tx_ref_external),
      .TX_SYM_EXP(tx_sym_exp), .TX_MOD_TYPE(tx_mod_type), .TX_MOD_VALID(tx_mod_valid),
      .TX_Q_INVERT(tx_q_invert), .TX_FILTER_BYPASS(tx_filter_bypass),
      .TX_SOURCE(tx_source), .TX_SOURCE_VALID(tx_source_valid), .TX_GAIN(tx_gain),
      .TX_CENTER_FREQ(tx_center_freq), .TX_FEC_CODE(tx_fec_code),
      .TX_FEC_VALID(tx_fec_valid), .TX_FEC_BYPASS(tx_fec_bypass),
      .TX_DIFF_ENCODE(tx_diff_encode), .TX_SCRAMBLE_BYPASS(tx_scramble_bypass),
      .TX_HDLC_BYPASS(tx_hdlc_bypass), .TX_INPUT_BIT_RATE(tx_input_bit_rate),
      .TX_EXT_GAIN(tx_ext_gain), .TRANSMIT_ENABLE_OUT(transmit_enable_out),
      .RECEIVE_NOT_TRANSMIT_OUT(receive_not_transmit_out), .RX_SCAN_STEPS(rx_scan_steps),
      .RX_SYMBOL_RATE(rx_symbol_rate), .RX_CENTER_FREQ(rx_center_freq),
      .RX_MOD_TYPE(rx_mod_type), .RX_MOD_VALID(rx_mod_valid), .RX_Q_INVERT(rx_q_invert),
      .RX_HIGH_SNR(rx_high_snr), .RX_AGC_EXP(rx_agc_exp), .RX_AGC_EXTERNAL(rx_agc_external),
      .RX_AGC_MAX_GAIN(rx_agc_max_gain), .RX_INPUT_SEL(rx_input_sel),
      .RX_INPUT_VALID(rx_input_valid), .RX_FEC_CODE(rx_fec_code),
      .RX_FEC_VALID(rx_fec_valid), .RX_DIFF_DECODE(rx_diff_decode));

   // one compare, four-state exact
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      if (n_fail == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      u_uc.write_byte(a, d);
   endtask

   // low byte first, so the top byte lands last
   task automatic wr_word(input logic [7:0] base, input int n, input logic [31:0] v);
      for (int i = 0; i < n; i++)
         wr(base + 8'(i), v[8*i +: 8]);
   endtask

   // reset pulse of two clocks, then the cleared state
   task automatic t_reset();
      #1 rst = 1'b1;
      repeat (2) @(posedge clk);
      #1 rst = 1'b0;
      check({tx_ext_gain, tx_clock_word}, 32'h0);
      check({tx_gain, rx_scan_steps}, 32'h0);
      check(tx_center_freq | rx_symbol_rate, 32'h0);
      check(rx_center_freq | tx_input_bit_rate, 32'h0);
      check(tx_sym_exp, `PMCR_SYM_EXP_MIN);
      check(rx_agc_max_gain, `PMCR_AGC_MAX_GAIN);
      check({tx_source_valid, tx_mod_valid, rx_mod_valid, rx_input_valid}, 4'hf);
      check({tx_fec_valid, rx_fec_valid}, 2'b00);
      // a write right after release still lands
      wr(`PMCR_OFS_TX_SRC, 8'h05);
      check(tx_source, `PMCR_SRC_CARRIER);
   endtask

   task automatic t_source();
      logic [3:0] c;
      for (int i = 0; i < 16; i++)
      begin
         c = 4'(i);
         wr(`PMCR_OFS_TX_SRC, {~c, c});
         check(tx_source, c);
         check(tx_source_valid, c <= `PMCR_SRC_PRBS || c == `PMCR_SRC_CARRIER);
      end
   endtask

   // every code in bits 4:1 on both coding bytes
   task automatic t_coding();
      logic [7:0] d;
      logic [7:0] e;
      for (int i = 0; i < 16; i++)
      begin
         d = 8'(i * 17);
         e = ~d;
         wr(`PMCR_OFS_TX_CODING, d);
         wr(`PMCR_OFS_RX_DECODING, e);
         check({tx_fec_code, tx_fec_bypass, tx_diff_encode}, {d[4:1], d[6], d[5]});
         check({tx_scramble_bypass, tx_hdlc_bypass}, {d[7], d[0]});
         check(tx_fec_valid, d[4:1] >= 4'h1 && d[4:1] <= 4'h5);
         check({rx_fec_code, rx_diff_decode}, {e[4:1], e[5]});
         check(rx_fec_valid, e[4:1] >= 4'h1 && e[4:1] <= 4'h5);
      end
   endtask

   task automatic t_modulation();
      logic [7:0] tab [5] = '{8'h00, 8'h41, 8'h82, 8'hc3, 8'h3f};
      logic [7:0] d;
      logic [7:0] e;
      foreach (tab[i])
      begin
         d = tab[i];
         e = {~d[7:6], d[5:0]};
         wr(`PMCR_OFS_TX_MOD, d);
         wr(`PMCR_OFS_RX_MOD, e);
         check({tx_mod_type, tx_q_invert, tx_filter_bypass}, {d[5:0], d[6], d[7]});
         check(tx_mod_valid, d[5:0] <= 6'h02);
         check({rx_mod_type, rx_q_invert, rx_high_snr, rx_mod_valid},
            {e[5:0], e[6], e[7], e[5:0] <= 6'h02});
      end
   endtask

   // word only moves when its top byte is written
   task automatic t_clock();
      wr(`PMCR_OFS_CLK_LO, 8'h34);
      wr(`PMCR_OFS_CLK_MID, 8'h12);
      check(tx_clock_word, 20'h0);
      wr(`PMCR_OFS_CLK_HI, 8'hf5);
      check({tx_ref_external, tx_clock_word}, {1'b1, 20'h51234});
      wr_word(`PMCR_OFS_CLK_LO, 3, 32'h066665);
      check({tx_ref_external, tx_clock_word}, {1'b0, 20'h66665});
      wr_word(`PMCR_OFS_CLK_LO, 3, 32'h066667);
      check(tx_clock_word, `PMCR_CLK_WORD_MAX);
   endtask

   task automatic t_words();
      wr_word(`PMCR_OFS_TXF_B0, 3, 32'h00a1b2c3);
      check(tx_center_freq, 32'h0);
      wr(`PMCR_OFS_TXF_B3, 8'hd4);
      check(tx_center_freq, 32'hd4a1b2c3);
      wr_word(`PMCR_OFS_GAIN_LO, 2, 32'h8001);
      check(tx_gain, 16'h8001);
      wr_word(`PMCR_OFS_RSR_B0, 4, 32'h051eb852);
      check(rx_symbol_rate, 32'h051eb852);
      wr_word(`PMCR_OFS_RXF_B0, 4, 32'hc0000001);
      check(rx_center_freq, 32'hc0000001);
      wr_word(`PMCR_OFS_IBR_B0, 3, 32'h001eb852);
      check(tx_input_bit_rate, 32'h0);
      wr(`PMCR_OFS_IBR_B3, 8'h05);
      check(tx_input_bit_rate, 32'h051eb852);
      wr_word(`PMCR_OFS_EXT_GAIN_LO, 2, 32'hfabc);
      check(tx_ext_gain, 12'habc);
   endtask

   task automatic t_misc();
      logic [2:0] c;
      wr(`PMCR_OFS_SYM_EXP, 8'h00);
      check(tx_sym_exp, 4'h1);
      wr(`PMCR_OFS_SYM_EXP, 8'hf7);
      check(tx_sym_exp, 4'h7);
      wr(`PMCR_OFS_SCAN, 8'h80);
      check(rx_scan_steps, 8'h80);
      wr(`PMCR_OFS_AGC, 8'h0f);
      check({rx_agc_external, rx_agc_exp, rx_agc_max_gain}, {1'b0, 5'h0e, 9'h100});
      wr(`PMCR_OFS_AGC, 8'h8d);
      check({rx_agc_external, rx_agc_exp, rx_agc_max_gain}, {1'b1, 5'h0d, 9'h000});
      wr(`PMCR_OFS_EXT_CTRL, 8'hfd);
      check({transmit_enable_out, receive_not_transmit_out}, 2'b10);
      wr(`PMCR_OFS_EXT_CTRL, 8'h02);
      check({transmit_enable_out, receive_not_transmit_out}, 2'b01);
      for (int i = 0; i < 8; i++)
      begin
         c = 3'(i);
         wr(`PMCR_OFS_RX_INPUT, {5'h15, c});
         check(rx_input_sel, c);
         check(rx_input_valid, c <= `PMCR_IN_COMPLEX || c == `PMCR_IN_LOOPBACK);
      end
   endtask

   // offsets past the bank, one aliasing the scan byte in six bits
   task automatic t_unmapped();
      wr(8'h58, 8'hff);
      wr(`PMCR_NUM_REGS, 8'hff);
      check(rx_scan_steps, 8'h80);
      check(tx_center_freq, 32'hd4a1b2c3);
   endtask

   // hang guard, far above the expected run
   initial
   begin
      #200us;
      n_fail++;
      print_verdict();
   end

   initial
   begin
      repeat (2) @(posedge clk);
      #1 rst = 1'b0;
      t_source();
      t_coding();
      t_modulation();
      t_clock();
      t_words();
      t_misc();
      t_unmapped();
      t_reset();
      print_verdict();
   end
endmodule
